// file: rtl/img_pkg.sv
// Constants shared by the interrupt mask gate and its port checks.
// Assumes a 32-bit register port with word-aligned byte offsets.

package img_pkg;

   //////////////////////////////////////////////////////////////////////////////
   // Register port.
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // Byte offsets of the registers.
   localparam logic [11:0] OFS_MASK_SET = 12'h088;
   localparam logic [11:0] OFS_MASK_CLEAR = 12'h08C;
   localparam logic [11:0] OFS_DIAG_STATUS = 12'h1F0;
   localparam logic [11:0] OFS_DIAG_MASK = 12'h1F4;
   localparam logic [11:0] OFS_EVENT_VIEW = 12'h1F8;

   //////////////////////////////////////////////////////////////////////////////
   // Field positions of the enable mask.
   localparam int GATE_BIT = 31;
   localparam int MAKER_BIT = 30;
   localparam int SOFT_BIT = 29;
   localparam int TIMED_RX_BIT = 7;
   localparam int TIMED_TX_BIT = 6;

   // Bits of the mask that hold state; bit 28 and bits 14 to 10 are reserved.
   localparam logic [31:0] MASK_WRITABLE = 32'hEFFF_83FF;
   // Bits of the event word that have an enable of their own.
   localparam logic [31:0] EVENT_GATED = 32'h6FFF_83FF;
   // Reset value of the mask.
   localparam logic [31:0] MASK_RESET = 32'h0000_0000;

   //////////////////////////////////////////////////////////////////////////////
   // Diagnostic status bits of the block itself.
   localparam int DIAG_W = 3;
   localparam int DIAG_IRQ_RISE = 0;
   localparam int DIAG_UNMAPPED = 1;
   localparam int DIAG_RSVD_WRITE = 2;
   localparam logic [2:0] DIAG_RESET = 3'h0;

   // Number of timed contexts per direction.
   localparam int CTX_N = 8;

endpackage

// file: rtl/img_ctx_summary.sv
// Unlatched summary of one direction of timed contexts.
// Assumes the context event and mask vectors are registered upstream.
`timescale 1ns/100ps

module img_ctx_summary #(
   parameter int N = 8
) (
   // Per-context event and enable bits.
   input wire logic [N-1:0] ctx_event,
   input wire logic [N-1:0] ctx_mask,
   // OR of the enabled context events.
   output logic summary
);

   // No latch here: the summary falls as soon as the contexts are cleared.
   assign summary = |(ctx_event & ctx_mask);

endmodule

// file: rtl/img_gate.sv
// Interrupt enable mask and processor interrupt gate.
// Assumes synchronous inputs, a single 10 MHz clock and a one-cycle strobe port.
`timescale 1ns/100ps

module img_gate #(
   parameter int CTX = img_pkg::CTX_N
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rstn,
   // Register port.
   input wire logic [img_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [img_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [img_pkg::DATA_W-1:0] reg_rdata,
   // Event flags kept by the event register outside.
   input wire logic [31:0] interrupt_event_flags,
   // Timed receive contexts.
   input wire logic [CTX-1:0] rx_ctx_event,
   input wire logic [CTX-1:0] rx_ctx_mask,
   // Timed transmit contexts.
   input wire logic [CTX-1:0] tx_ctx_event,
   input wire logic [CTX-1:0] tx_ctx_mask,
   // Processor interrupt and views.
   output logic host_irq,
   output logic [31:0] masked_event_view,
   output logic [31:0] interrupt_enable_mask,
   output logic timed_receive_summary,
   output logic timed_transmit_summary,
   // Diagnostic interrupt of the block itself.
   output logic diag_irq
);

   //////////////////////////////////////////////////////////////////////////////
   // Address decoding.

   // Tells whether an address is one of the two mask ports.
   function automatic logic is_mask_port(input logic [img_pkg::ADDR_W-1:0] a);
      logic hit;
      hit = 1'b0;
      if (a == img_pkg::OFS_MASK_SET) begin
         hit = 1'b1;
      end else if (a == img_pkg::OFS_MASK_CLEAR) begin
         hit = 1'b1;
      end
      return hit;
   endfunction

   // Tells whether an address lands on any register of the block.
   function automatic logic is_mapped(input logic [img_pkg::ADDR_W-1:0] a);
      logic hit;
      hit = 1'b0;
      if (is_mask_port(a)) begin
         hit = 1'b1;
      end else if (a == img_pkg::OFS_DIAG_STATUS) begin
         hit = 1'b1;
      end else if (a == img_pkg::OFS_DIAG_MASK) begin
         hit = 1'b1;
      end else if (a == img_pkg::OFS_EVENT_VIEW) begin
         hit = 1'b1;
      end
      return hit;
   endfunction

   //////////////////////////////////////////////////////////////////////////////
   // Declarations.

   logic [1:0] rst_sync_q;
   logic rst_n;
   logic [31:0] mask_q;
   logic [31:0] mask_d;
   logic [31:0] masked_q;
   logic [31:0] masked_d;
   logic [31:0] events_eff;
   logic irq_q;
   logic irq_d;
   logic [1:0] summary_w;
   logic [1:0] summary_q;
   logic [img_pkg::DIAG_W-1:0] diag_st_q;
   logic [img_pkg::DIAG_W-1:0] diag_st_d;
   logic [img_pkg::DIAG_W-1:0] diag_set;
   logic [img_pkg::DIAG_W-1:0] diag_clr;
   logic [img_pkg::DIAG_W-1:0] diag_mask_q;
   logic diag_irq_q;
   logic [img_pkg::DATA_W-1:0] rdata_q;
   logic [img_pkg::DATA_W-1:0] rdata_d;
   logic wr_set;
   logic wr_clear;
   logic rsvd_write;
   logic bad_access;

   //////////////////////////////////////////////////////////////////////////////
   // Reset release.

   // The async reset is released through two flops so all state leaves reset together.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   // Only the second flop is used as the internal reset.
   assign rst_n = rst_sync_q[1];

   //////////////////////////////////////////////////////////////////////////////
   // Timed context summaries.

   // One summary per direction; index 0 is transmit, index 1 is receive.
   generate
      for (genvar g = 0; g < 2; g++) begin : g_sum
         img_ctx_summary #(
            .N(CTX)
         ) u_sum (
            .ctx_event((g == 0) ? tx_ctx_event : rx_ctx_event),
            .ctx_mask((g == 0) ? tx_ctx_mask : rx_ctx_mask),
            .summary(summary_w[g])
         );
      end
   endgenerate

   // The summaries replace the event word at their own positions.
   always_comb begin
      events_eff = interrupt_event_flags;
      events_eff[img_pkg::TIMED_RX_BIT] = summary_w[1];
      events_eff[img_pkg::TIMED_TX_BIT] = summary_w[0];
      // Reserved event positions and the gate position carry no enable.
      events_eff = events_eff & img_pkg::EVENT_GATED;
   end

   //////////////////////////////////////////////////////////////////////////////
   // Write strobes.

   // Split a write into a set or a clear of the mask.
   always_comb begin
      wr_set = 1'b0;
      wr_clear = 1'b0;
      if (reg_wr && (reg_addr == img_pkg::OFS_MASK_SET)) begin
         wr_set = 1'b1;
      end else if (reg_wr && (reg_addr == img_pkg::OFS_MASK_CLEAR)) begin
         wr_clear = 1'b1;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Enable mask.

   // Ones set or clear bits, zeros leave them; reserved bits never take a one.
   always_comb begin
      mask_d = mask_q;
      if (wr_set) begin
         mask_d = (mask_q | reg_wdata) & img_pkg::MASK_WRITABLE;
      end else if (wr_clear) begin
         mask_d = mask_q & ~reg_wdata & img_pkg::MASK_WRITABLE;
      end
   end

   // The mask itself; every bit starts cleared, gate included.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mask_q <= img_pkg::MASK_RESET;
      end else begin
         mask_q <= mask_d;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Gating.

   // Each enable sits on its own event position, so a plain AND does the gating.
   // This covers the maker-defined bit 30, the software bit 29 and both runs of events.
   always_comb begin
      masked_d = events_eff & mask_q;
   end

   // The gate only acts on the interrupt line, never on the masked view.
   always_comb begin
      irq_d = 1'b0;
      if (mask_q[img_pkg::GATE_BIT]) begin
         irq_d = |masked_d;
      end else begin
         irq_d = 1'b0;
      end
   end

   // Registered masked view, unaffected by the gate.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         masked_q <= 32'h0000_0000;
      end else begin
         masked_q <= masked_d;
      end
   end

   // Registered processor interrupt, one cycle behind its cause.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
      end
   end

   // Registered copies of the two summaries for the outside.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         summary_q <= 2'h0;
      end else begin
         summary_q <= summary_w;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Diagnostic status.

   // A write of a one to a reserved bit is dropped but noted.
   assign rsvd_write = (wr_set || wr_clear) && ((reg_wdata & ~img_pkg::MASK_WRITABLE) != 32'h0);

   // Any strobe to an address with no register is noted.
   assign bad_access = (reg_wr || reg_rd) && !is_mapped(reg_addr);

   // Events of the block: interrupt rising, unmapped access, reserved write.
   always_comb begin
      diag_set = '0;
      diag_set[img_pkg::DIAG_IRQ_RISE] = irq_d && !irq_q;
      diag_set[img_pkg::DIAG_UNMAPPED] = bad_access;
      diag_set[img_pkg::DIAG_RSVD_WRITE] = rsvd_write;
   end

   // Writing ones to the status register clears those bits.
   always_comb begin
      diag_clr = '0;
      if (reg_wr && (reg_addr == img_pkg::OFS_DIAG_STATUS)) begin
         diag_clr = reg_wdata[img_pkg::DIAG_W-1:0];
      end
   end

   // A set in the same cycle as its clear wins, so no event is lost.
   assign diag_st_d = (diag_st_q & ~diag_clr) | diag_set;

   // Sticky status bits.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         diag_st_q <= img_pkg::DIAG_RESET;
      end else begin
         diag_st_q <= diag_st_d;
      end
   end

   // Mask of the diagnostic status, plain read and write.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         diag_mask_q <= img_pkg::DIAG_RESET;
      end else if (reg_wr && (reg_addr == img_pkg::OFS_DIAG_MASK)) begin
         diag_mask_q <= reg_wdata[img_pkg::DIAG_W-1:0];
      end
   end

   // Level interrupt, high while an unmasked status bit is set.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         diag_irq_q <= 1'b0;
      end else begin
         diag_irq_q <= |(diag_st_q & diag_mask_q);
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Read path.

   // Read data stand only in the cycle after the strobe; otherwise zero.
   always_comb begin
      rdata_d = '0;
      if (reg_rd) begin
         if (is_mask_port(reg_addr)) begin
            rdata_d = mask_q;
         end else if (reg_addr == img_pkg::OFS_DIAG_STATUS) begin
            rdata_d[img_pkg::DIAG_W-1:0] = diag_st_q;
         end else if (reg_addr == img_pkg::OFS_DIAG_MASK) begin
            rdata_d[img_pkg::DIAG_W-1:0] = diag_mask_q;
         end else if (reg_addr == img_pkg::OFS_EVENT_VIEW) begin
            rdata_d = events_eff;
         end else begin
            rdata_d = '0;
         end
      end
   end

   // Read data register.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Outputs, each straight from a flop.

   assign reg_rdata = rdata_q;
   assign host_irq = irq_q;
   assign masked_event_view = masked_q;
   assign interrupt_enable_mask = mask_q;
   assign timed_transmit_summary = summary_q[0];
   assign timed_receive_summary = summary_q[1];
   assign diag_irq = diag_irq_q;

endmodule

// file: bench/img_gate_asserts.sv
// Port-level checks for the interrupt mask gate.
// Bound to img_gate; sees its ports only, one clock domain.
`timescale 1ns/100ps

module img_gate_asserts #(
   parameter int CTX = 8
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rstn,
   // Register port.
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // Events and contexts.
   input wire logic [31:0] interrupt_event_flags,
   input wire logic [CTX-1:0] rx_ctx_event,
   input wire logic [CTX-1:0] rx_ctx_mask,
   input wire logic [CTX-1:0] tx_ctx_event,
   input wire logic [CTX-1:0] tx_ctx_mask,
   // Outputs watched.
   input wire logic host_irq,
   input wire logic [31:0] masked_event_view,
   input wire logic [31:0] interrupt_enable_mask,
   input wire logic timed_receive_summary,
   input wire logic timed_transmit_summary,
   input wire logic diag_irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);

   ////////////////////////////////////////
   // Counts edges after release, since the synchronised reset lingers for two.
   logic [1:0] up_q;
   logic up;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         up_q <= 2'h0;
      end else if (up_q != 2'h2) begin
         up_q <= up_q + 2'h1;
      end
   end
   assign up = up_q == 2'h2;

   // Effective event word, with the two summaries in bits 7 and 6.
   logic [31:0] eff;
   logic cause;
   assign eff = (interrupt_event_flags & img_pkg::EVENT_GATED & 32'hFFFF_FF3F)
      | {24'h0, |(rx_ctx_event & rx_ctx_mask), |(tx_ctx_event & tx_ctx_mask), 6'h0};
   assign cause = interrupt_enable_mask[31] && |(eff & interrupt_enable_mask);

   ////////////////////////////////////////
   property p_irq_on;
      up && cause |=> host_irq;
   endproperty
   a_irq_on: assert property (p_irq_on) else $error("irq not raised");
   property p_gate_off;
      up && !interrupt_enable_mask[31] |=> !host_irq;
   endproperty
   a_gate_off: assert property (p_gate_off) else $error("irq with gate off");
   property p_masked_off;
      up && (eff & interrupt_enable_mask) == 32'h0 |=> !host_irq;
   endproperty
   a_masked_off: assert property (p_masked_off) else $error("irq from masked");
   property p_view;
      up |=> masked_event_view == $past(eff & interrupt_enable_mask);
   endproperty
   a_view: assert property (p_view) else $error("masked view wrong");
   property p_rsvd;
      (interrupt_enable_mask & ~img_pkg::MASK_WRITABLE) == 32'h0;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
   property p_set;
      up && reg_wr && reg_addr == img_pkg::OFS_MASK_SET |=> interrupt_enable_mask ==
         ($past(interrupt_enable_mask) | ($past(reg_wdata) & img_pkg::MASK_WRITABLE));
   endproperty
   a_set: assert property (p_set) else $error("set port wrong");
   property p_clr;
      up && reg_wr && reg_addr == img_pkg::OFS_MASK_CLEAR |=>
         interrupt_enable_mask == ($past(interrupt_enable_mask) & ~$past(reg_wdata));
   endproperty
   a_clr: assert property (p_clr) else $error("clear port wrong");
   property p_hold;
      up && !reg_wr |=> $stable(interrupt_enable_mask);
   endproperty
   a_hold: assert property (p_hold) else $error("mask changed unasked");
   property p_read;
      reg_rd && (reg_addr == img_pkg::OFS_MASK_SET || reg_addr == img_pkg::OFS_MASK_CLEAR)
         |=> reg_rdata == $past(interrupt_enable_mask);
   endproperty
   a_read: assert property (p_read) else $error("mask read wrong");
   property p_summary;
      up |=> timed_receive_summary == $past(|(rx_ctx_event & rx_ctx_mask))
         && timed_transmit_summary == $past(|(tx_ctx_event & tx_ctx_mask));
   endproperty
   a_summary: assert property (p_summary) else $error("summary wrong");

   // Main scenarios reached.
   c_irq: cover property (up && host_irq);
   c_rx: cover property (up && masked_event_view[7]);
   c_rsvd_wr: cover property (reg_wr && reg_wdata[28]);
endmodule

bind img_gate img_gate_asserts #(.CTX(CTX)) img_gate_asserts_i (
   .clock, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .interrupt_event_flags, .rx_ctx_event, .rx_ctx_mask, .tx_ctx_event, .tx_ctx_mask,
   .host_irq, .masked_event_view, .interrupt_enable_mask, .timed_receive_summary,
   .timed_transmit_summary, .diag_irq);

// file: bench/testbench.sv
// Self-checking bench for the interrupt mask gate.
// Drives every input port of img_gate itself from one 10 MHz clock.
`timescale 1ns/100ps

module testbench;
   typedef struct {
      logic [11:0] a;
      logic [31:0] d;
      logic [31:0] e;
      logic [31:0] m;
      logic q;
   } img_row_t;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] interrupt_event_flags = 32'h0000_0000;
   logic [7:0] rx_ctx_event = 8'h00, rx_ctx_mask = 8'h00;
   logic [7:0] tx_ctx_event = 8'h00, tx_ctx_mask = 8'h00;
   logic host_irq, timed_receive_summary, timed_transmit_summary, diag_irq;
   logic [31:0] reg_rdata, masked_event_view, interrupt_enable_mask, rd;
   int n_mismatch = 0;
   int total_checks = 0;
   int cyc = 0;
   // Write, then the flags shown, then mask and interrupt expected.
   img_row_t rows [10] = '{
      '{12'h088, 32'hFFFF_FFFF, 32'h0000_0000, 32'hEFFF_83FF, 1'b0},
      '{12'h08C, 32'h8000_0000, 32'h0000_0001, 32'h6FFF_83FF, 1'b0},
      '{12'h088, 32'h8000_0000, 32'h0000_0001, 32'hEFFF_83FF, 1'b1},
      '{12'h08C, 32'h0000_0001, 32'h0000_0001, 32'hEFFF_83FE, 1'b0},
      '{12'h08C, 32'h4000_0000, 32'h4000_0000, 32'hAFFF_83FE, 1'b0},
      '{12'h088, 32'h4000_0000, 32'h4000_0000, 32'hEFFF_83FE, 1'b1},
      '{12'h08C, 32'h0000_0000, 32'h2000_0000, 32'hEFFF_83FE, 1'b1},
      '{12'h08C, 32'h0000_0000, 32'h1000_7CC0, 32'hEFFF_83FE, 1'b0},
      '{12'h08C, 32'h0000_0000, 32'h0000_8000, 32'hEFFF_83FE, 1'b1},
      '{12'h08C, 32'h0000_0000, 32'h0000_0200, 32'hEFFF_83FE, 1'b1}};

   img_gate img_gate_i (
      .clock, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .interrupt_event_flags, .rx_ctx_event, .rx_ctx_mask, .tx_ctx_event, .tx_ctx_mask,
      .host_irq, .masked_event_view, .interrupt_enable_mask, .timed_receive_summary,
      .timed_transmit_summary, .diag_irq);

   ////////////////////////////////////////
   // Clock of 100 ns period, and a ceiling on the run length.
   always #50 clock = ~clock;
   always @(posedge clock) begin
      cyc++;
      if (cyc == 1000) begin
         n_mismatch++;
         report_and_stop();
      end
   end

   // Counts a comparison and reports a difference.
   task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // One-cycle write strobe, then one idle edge so a next call never re-drives the strobe.
   task automatic wr(logic [11:0] a, logic [31:0] d);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
      @(posedge clock);
   endtask
   // One-cycle read strobe; the data are taken at the next edge, before it replaces them.
   task automatic rdr(logic [11:0] a);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(posedge clock);
      rd = reg_rdata;
   endtask
   // Lets two edges pass; registered outputs are read as they stand before the second one.
   task automatic settle();
      repeat (2) @(posedge clock);
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   ////////////////////////////////////////
   // Reset, table rows, then the awkward cases.
   initial begin
      repeat (20) @(posedge clock);
      rstn <= 1'b1;
      repeat (3) @(posedge clock);
      chk("mask reset", interrupt_enable_mask & 32'h0000_F000, 32'h0);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         interrupt_event_flags <= rows[i].e;
         settle();
         chk("mask", interrupt_enable_mask, rows[i].m);
         chk("irq", {31'h0, host_irq}, {31'h0, rows[i].q});
         chk("view", masked_event_view, rows[i].e & rows[i].m & 32'h6FFF_833F);
         rdr(12'h088);
         chk("set port", rd, rows[i].m);
         rdr(12'h08C);
         chk("clear port", rd, rows[i].m);
      end
      interrupt_event_flags <= 32'h0;
      rx_ctx_event <= 8'h10;
      rx_ctx_mask <= 8'h10;
      settle();
      chk("rx sum", {timed_receive_summary, host_irq}, 2'h3);
      chk("rx view", masked_event_view, 32'h0000_0080);
      rdr(12'h1F8);
      chk("event word", rd, 32'h0000_0080);
      rx_ctx_mask <= 8'h0F;
      tx_ctx_event <= 8'h01;
      tx_ctx_mask <= 8'h03;
      settle();
      chk("tx sum", {timed_receive_summary, timed_transmit_summary}, 2'h1);
      wr(12'h1F4, 32'h0);
      wr(12'h1F0, 32'h7);
      wr(12'h100, 32'hFFFF_FFFF);
      rdr(12'h100);
      chk("unmapped read", rd, 32'h0);
      rdr(12'h1F0);
      chk("diag status", rd & 32'h6, 32'h2);
      chk("diag masked", {31'h0, diag_irq}, 32'h0);
      wr(12'h1F4, 32'h2);
      settle();
      chk("diag irq", {31'h0, diag_irq}, 32'h1);
      wr(12'h1F0, 32'h2);
      settle();
      chk("diag cleared", {31'h0, diag_irq}, 32'h0);
      wr(12'h088, 32'h1000_0000);
      rdr(12'h1F0);
      chk("rsvd write", rd & 32'h6, 32'h4);
      rdr(12'h08C);
      chk("mask kept", rd, 32'hEFFF_83FE);
      rstn <= 1'b0;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      repeat (3) @(posedge clock);
      rdr(12'h088);
      chk("mask re-reset", rd & 32'h0000_F000, 32'h0);
      report_and_stop();
   end
endmodule
